// file: src/wake_pkg.sv
/*
  shared constants and types for the wake-event / power-state link.
  assumes a single 40 MHz clock shared by both ends.
*/
package wake_pkg;
  // ----------------------------------------
  // device power states
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSTATE_D0 = 2'h0,
    DSTATE_D1 = 2'h1,
    DSTATE_D2 = 2'h2,
    DSTATE_D3 = 2'h3
  } dstate_t;

  // ----------------------------------------
  // controller register map (word offsets)
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0; // [1:0] target state, [8] resource on, [9] sleep
  localparam logic [3:0] REG_ENABLE = 4'h1; // [0] power-status sci, [1] wake enable
  localparam logic [3:0] REG_STATUS = 4'h2; // [0] power-status, [1] wake; write 1 clears
  localparam logic [3:0] REG_STATE  = 4'h3; // [1:0] device state, [8] resource, [9] sleeping,
                                            // [10] busy, [11] sci
  localparam logic [3:0] REG_SETTLE = 4'h4; // stabilization cycles

  localparam int          CTRL_RES_BIT   = 8;
  localparam int          CTRL_SLEEP_BIT = 9;
  localparam int          EVT_PWR_BIT    = 0;
  localparam int          EVT_WAKE_BIT   = 1;

  localparam logic [15:0] SETTLE_RST     = 16'h0028; // 1 us at 40 MHz
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
endpackage : wake_pkg

// file: src/wake_link_if.sv
/*
  link between the power-state controller and one managed device.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface wake_link_if;
  import wake_pkg::*;
  logic    set_vld;   // set-power-state command strobe
  dstate_t set_state; // commanded state
  logic    pwr_on;    // power resource enable
  logic    wake_en;   // device sci / wake enable
  dstate_t cur_state; // state reported by device
  logic    wake_req;  // wake signal forwarded upstream (level)
  logic    pstat_evt; // power-status change pulse

  modport ctrl (output set_vld, set_state, pwr_on, wake_en,
                input  cur_state, wake_req, pstat_evt);
  modport dev  (input  set_vld, set_state, pwr_on, wake_en,
                output cur_state, wake_req, pstat_evt);
endinterface : wake_link_if

// file: src/wake_device_end.sv
/*
  managed device end: power-state register, low-power gating, wake forwarding.
  assumes the controller powers the device before commanding it.
*/
`timescale 1ns/1ps
module wake_device_end
  import wake_pkg::*;
(
  input  wire logic    clk_i,        // 40 MHz clock
  input  wire logic    rst_n_i,      // async reset, active low
  wake_link_if.dev     link,         // toward controller
  input  wire logic    ring_i,       // local wake source (level)
  input  wire logic    batt_low_i,   // local power-status condition
  output logic         func_en_o,    // full function allowed (D0)
  output logic         clk_gate_o,   // functional clock enabled (D0/D1)
  output logic         aux_on_o      // wake logic kept alive
);
  // ----------------------------------------
  // state register
  // ----------------------------------------
  dstate_t st_r;
  logic    batt_r;
  logic    wake_r;
  logic    pstat_r;

  wire take_cmd  = link.set_vld && link.pwr_on;
  wire batt_edge = batt_low_i ^ batt_r;
  // wake works with processor and main power off: pure hardware
  wire wake_nxt  = ring_i && link.wake_en;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= DSTATE_D0;
      batt_r  <= 1'b0;
      wake_r  <= 1'b0;
      pstat_r <= 1'b0;
      func_en_o  <= 1'b1;
      clk_gate_o <= 1'b1;
      aux_on_o   <= 1'b0;
    end else begin
      if (take_cmd) begin
        st_r <= link.set_state;
      end
      batt_r  <= batt_low_i;
      wake_r  <= wake_nxt;
      pstat_r <= batt_edge;
      // lower states shed load
      func_en_o  <= (st_r == DSTATE_D0) && link.pwr_on;
      clk_gate_o <= ((st_r == DSTATE_D0) || (st_r == DSTATE_D1)) && link.pwr_on;
      aux_on_o   <= link.wake_en;
    end
  end

  assign link.cur_state = st_r;
  assign link.wake_req  = wake_r;
  assign link.pstat_evt = pstat_r;
endmodule : wake_device_end

// file: src/wake_ctrl_end.sv
/*
  core-logic controller end: power resource sequencing with settle timing,
  sticky sci status, wake resume. registers over a plain strobe port.
  assumes one managed device on the link and register strobes one cycle long.
  with the resource request low, power is held until the device reports D3
  or until software requests the resource again.
*/
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module wake_ctrl_end
  import wake_pkg::*;
(
  input  wire logic        clk_i,      // 40 MHz clock
  input  wire logic        rst_n_i,    // async reset, active low
  wake_link_if.ctrl        link,       // toward device
  input  wire logic [3:0]  addr_i,     // register word index
  input  wire logic [31:0] wdata_i,    // write data
  input  wire logic        wr_i,       // write strobe
  input  wire logic        rd_i,       // read strobe
  output logic      [31:0] rdata_o,    // read data, one cycle later
  output logic             sci_o,      // system control interrupt
  output logic             resume_o,   // machine resume pulse
  output logic             bus_off_o,  // bus power removed
  output logic             bus_low_o   // bus reduced supply
);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  // only one link command is ever in flight
  typedef enum logic [1:0] {
    SQ_IDLE   = 2'b00,
    SQ_SETTLE = 2'b01,
    SQ_CMD    = 2'b11,
    SQ_OFF    = 2'b10
  } seq_t;

  seq_t        seq_r;
  dstate_t     tgt_r;
  logic        res_r;
  logic        res_want_r;
  logic        sleep_r;
  // en_r[1] also drives the wake enable on the link
  logic [1:0]  en_r;
  logic [1:0]  stat_r;
  logic [15:0] settle_r;
  logic [15:0] cnt_r;
  logic        set_vld_r;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // unmapped addresses read zero and ignore writes
  wire wr_ctrl   = wr_i && (addr_i == REG_CTRL);
  wire wr_enable = wr_i && (addr_i == REG_ENABLE);
  wire wr_status = wr_i && (addr_i == REG_STATUS);
  wire wr_settle = wr_i && (addr_i == REG_SETTLE);
  wire busy      = (seq_r != SQ_IDLE);

  wire pwr_hit  = link.pstat_evt && en_r[EVT_PWR_BIT];
  wire wake_hit = link.wake_req && en_r[EVT_WAKE_BIT];
  wire [1:0] evt_set = {wake_hit, pwr_hit};
  wire [1:0] evt_clr = wr_status ? wdata_i[1:0] : 2'h0;
  // set wins over a clear in the same cycle, so no event is lost
  wire [1:0] stat_nxt = evt_set | (stat_r & ~evt_clr);

  // busy and sci are read live, so polling has no side effects
  wire [31:0] state_word = {20'h0, (|(stat_r & en_r)), busy, sleep_r, res_r,
                            6'h0, link.cur_state};
  wire [31:0] rd_mux =
      (addr_i == REG_CTRL)   ? {22'h0, sleep_r, res_want_r, 6'h0, tgt_r} :
      (addr_i == REG_ENABLE) ? {30'h0, en_r} :
      (addr_i == REG_STATUS) ? {30'h0, stat_r} :
      (addr_i == REG_STATE)  ? state_word :
      (addr_i == REG_SETTLE) ? {16'h0, settle_r} : ZERO_WORD;

  // resource must drop only once the device itself is off
  wire want_off = !res_want_r && res_r;

  // ----------------------------------------
  // registered output next values
  // ----------------------------------------
  // sci follows the status bits, so a clear and the line drop together
  wire        sci_nxt     = |(stat_nxt & en_r);
  // pulse only on the edge that really leaves sleep
  wire        resume_nxt  = sleep_r && wake_hit && !wr_ctrl;
  wire        dev_off     = (link.cur_state == DSTATE_D3);
  wire        dev_low     = (link.cur_state == DSTATE_D1) ||
                            (link.cur_state == DSTATE_D2);
  // one device per link: bus off needs D3 with the resource dropped, bus low follows the device state alone
  wire        bus_off_nxt = dev_off && !res_r;
  wire        bus_low_nxt = dev_low;
  // zero between reads, so a stale word never looks like an answer
  wire [31:0] rdata_nxt   = rd_i ? rd_mux : ZERO_WORD;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt_r      <= DSTATE_D0;
      res_want_r <= 1'b1;
      sleep_r    <= 1'b0;
      en_r       <= 2'h0;
      stat_r     <= 2'h0;
      settle_r   <= SETTLE_RST;
      rdata_o    <= ZERO_WORD;
      sci_o      <= 1'b0;
      resume_o   <= 1'b0;
      bus_off_o  <= 1'b0;
      bus_low_o  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        tgt_r      <= dstate_t'(wdata_i[1:0]);
        res_want_r <= wdata_i[CTRL_RES_BIT];
        sleep_r    <= wdata_i[CTRL_SLEEP_BIT];
      end else if (sleep_r && wake_hit) begin
        // a ctrl write in the wake cycle wins, keeping software's sleep bit
        sleep_r <= 1'b0;
      end
      if (wr_enable) begin
        en_r <= wdata_i[1:0];
      end
      if (wr_settle) begin
        settle_r <= wdata_i[15:0];
      end
      stat_r    <= stat_nxt;
      rdata_o   <= rdata_nxt;
      sci_o     <= sci_nxt;
      resume_o  <= resume_nxt;
      bus_off_o <= bus_off_nxt;
      bus_low_o <= bus_low_nxt;
    end
  end

  // ----------------------------------------
  // resource / command sequencer
  // ----------------------------------------
  // ctrl writes while busy only update the target, resource request and sleep bit
  wire power_up_req = wr_ctrl && wdata_i[CTRL_RES_BIT] && !res_r;
  wire cmd_req      = wr_ctrl && res_r;
  wire settle_done  = (cnt_r == 16'h0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_r     <= SQ_IDLE;
      res_r     <= 1'b1;
      cnt_r     <= 16'h0;
      set_vld_r <= 1'b0;
    end else begin
      set_vld_r <= 1'b0;
      case (seq_r)
        SQ_IDLE: begin
          if (power_up_req) begin
            res_r <= 1'b1;
            cnt_r <= settle_r;
            seq_r <= SQ_SETTLE;
          end else if (cmd_req) begin
            seq_r <= SQ_CMD;
          end
        end
        SQ_SETTLE: begin
          // zero is held one more cycle: settle+1 cycles in all
          if (settle_done) begin
            seq_r <= res_r ? SQ_CMD : SQ_IDLE;
          end else begin
            cnt_r <= cnt_r - 16'h1;
          end
        end
        SQ_CMD: begin
          set_vld_r <= 1'b1;
          seq_r     <= want_off ? SQ_OFF : SQ_IDLE;
        end
        SQ_OFF: begin
          // a fresh resource request leaves the off wait; otherwise a device
          // parked short of D3 would keep the sequencer busy for ever
          if (res_want_r) begin
            seq_r <= SQ_CMD;
          end else if (dev_off) begin
            res_r <= 1'b0;
            cnt_r <= settle_r;
            seq_r <= SQ_SETTLE;
          end
        end
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  assign link.set_vld   = set_vld_r;
  assign link.set_state = tgt_r;
  assign link.pwr_on    = res_r;
  assign link.wake_en   = en_r[EVT_WAKE_BIT];
endmodule : wake_ctrl_end

// file: testbench/wake_link_checker.sv
/* link checker: power-state commands and wake signalling on the link.
   assumes both ends share one clock; instantiated beside the link. */
`timescale 1ns/1ps
module wake_link_checker
  import wake_pkg::*;
(
  input wire logic    clk_i,     // clock
  input wire logic    rst_n_i,   // reset, low
  input wire logic    set_vld,   // command strobe
  input wire dstate_t set_state, // commanded state
  input wire logic    pwr_on,    // resource on
  input wire logic    wake_en,   // wake enable
  input wire dstate_t cur_state, // device state
  input wire logic    wake_req,  // wake level
  input wire logic    pstat_evt  // status pulse
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take; set_vld && pwr_on; endsequence
  // settle gap is sized for the short settle value written by the bench
  sequence s_quiet3; !set_vld [*3]; endsequence

  a_cmd_powered: assert property (set_vld |-> pwr_on)
    else $error("command sent while unpowered");
  a_state_taken: assert property (s_take |=> cur_state == $past(set_state))
    else $error("commanded state not taken");
  a_state_held: assert property (!set_vld && pwr_on |=> $stable(cur_state))
    else $error("state moved without command");
  a_cmd_pulse: assert property (set_vld |=> !set_vld)
    else $error("command strobe longer than one cycle");
  a_wake_gated: assert property (wake_req |-> $past(wake_en))
    else $error("wake forwarded while disabled");
  a_evt_pulse: assert property (pstat_evt |=> !pstat_evt)
    else $error("status event longer than one cycle");
  a_on_then_cmd: assert property ($rose(pwr_on) |-> s_quiet3 ##[1:60] set_vld)
    else $error("power-on not followed by settled command");
  a_off_after_d3: assert property ($fell(pwr_on) |-> cur_state == DSTATE_D3)
    else $error("resource dropped before device off");
endmodule // wake_link_checker

// file: testbench/wake_event_power_state_logic_tb_top.sv
/* bench: controller and device ends joined by the link.
   assumes register port reads answer one cycle after the strobe. */
`timescale 1ns/1ps
module wake_event_power_state_logic_tb_top;
  import wake_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ring_i = 1'b0;
  logic        batt_low_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o, rd_v;
  logic        sci_o, resume_o, bus_off_o, bus_low_o, func_en_o, clk_gate_o, aux_on_o;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  wake_link_if link_if_i ();
  wake_ctrl_end wake_ctrl_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sci_o(sci_o), .resume_o(resume_o), .bus_off_o(bus_off_o), .bus_low_o(bus_low_o));
  wake_device_end wake_device_end_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if_i),
    .ring_i(ring_i), .batt_low_i(batt_low_i), .func_en_o(func_en_o),
    .clk_gate_o(clk_gate_o), .aux_on_o(aux_on_o));
  wake_link_checker wake_link_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .set_vld(link_if_i.set_vld), .set_state(link_if_i.set_state), .pwr_on(link_if_i.pwr_on),
    .wake_en(link_if_i.wake_en), .cur_state(link_if_i.cur_state),
    .wake_req(link_if_i.wake_req), .pstat_evt(link_if_i.pstat_evt));

  initial forever #12.5 clk_i = ~clk_i;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rd_v = rdata_o;
    if (m != 32'h0) check(rd_v & m, e);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 40; n++) begin
      rd_chk(REG_STATE, 32'h0, 32'h0);
      if (rd_v[10] === 1'b0) return;
    end
    check(rd_v[10], 1'b0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_states();
    dstate_t s;
    for (int i = 1; i <= 4; i++) begin
      s = dstate_t'(i[1:0]);
      wr_reg(REG_CTRL, 32'h100 | 32'(s));
      wait_idle();
      rd_chk(REG_STATE, 32'h3, 32'(s));
      check({func_en_o, clk_gate_o, bus_low_o}, {s == 0, s < 2, s == 1 || s == 2});
    end
    wr_reg(REG_CTRL, 32'h3);
    wait_idle();
    rd_chk(REG_STATE, 32'h103, 32'h3);
    check({bus_off_o, func_en_o, clk_gate_o}, 3'b100);
    wr_reg(REG_CTRL, 32'h100);
    wait_idle();
    rd_chk(REG_STATE, 32'h103, 32'h100);
    check({bus_off_o, func_en_o}, 2'b01);
    wr_reg(REG_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    rd_chk(REG_STATE, 32'h503, 32'h501);
    wr_reg(REG_CTRL, 32'h100);
    wait_idle();
    rd_chk(REG_STATE, 32'h503, 32'h100);
    $display("power state test done");
  endtask
  task automatic t_wake();
    wr_reg(REG_CTRL, 32'h303);
    wait_idle();
    rd_chk(REG_STATE, 32'h203, 32'h203);
    @(posedge clk_i) ring_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ring_i <= 1'b0;
    rd_chk(REG_STATUS, 32'h3, 32'h0);
    rd_chk(REG_STATE, 32'h200, 32'h200);
    wr_reg(REG_ENABLE, 32'h2);
    repeat (2) @(negedge clk_i);
    check(aux_on_o, 1'b1);
    @(posedge clk_i) ring_i <= 1'b1;
    for (int n = 0; n < 6 && resume_o !== 1'b1; n++) @(negedge clk_i);
    check(resume_o, 1'b1);
    rd_chk(REG_STATUS, 32'h3, 32'h2);
    check(sci_o, 1'b1);
    rd_chk(REG_STATE, 32'h200, 32'h0);
    @(posedge clk_i) ring_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(REG_STATUS, 32'h3, 32'h2);
    wr_reg(REG_STATUS, 32'h2);
    rd_chk(REG_STATUS, 32'h3, 32'h0);
    check(sci_o, 1'b0);
    $display("wake test done");
  endtask
  task automatic t_pwr();
    wr_reg(REG_ENABLE, 32'h0);
    @(posedge clk_i) batt_low_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk(REG_STATUS, 32'h3, 32'h0);
    wr_reg(REG_ENABLE, 32'h1);
    @(posedge clk_i) batt_low_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(REG_STATUS, 32'h3, 32'h1);
    check(sci_o, 1'b1);
    wr_reg(REG_ENABLE, 32'h0);
    rd_chk(REG_STATUS, 32'h3, 32'h1);
    check(sci_o, 1'b0);
    wr_reg(REG_STATUS, 32'h1);
    rd_chk(REG_STATUS, 32'h3, 32'h0);
    $display("power status test done");
  endtask
  task automatic stop_test();
    $display("checks %0d, failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // run is under two hundred cycles; ceiling leaves wide margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      $display("CHECK FAILED t=%0t timeout", $time);
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(REG_SETTLE, 32'hffff, {16'h0, SETTLE_RST});
    rd_chk(REG_STATE, 32'hf03, 32'h100);
    rd_chk(4'hf, 32'hffffffff, 32'h0);
    check({func_en_o, clk_gate_o, aux_on_o}, 3'b110);
    wr_reg(REG_SETTLE, 32'h2);
    t_states();
    t_wake();
    t_pwr();
    stop_test();
  end
endmodule // wake_event_power_state_logic_tb_top
